// file: rtl/psfm_pkg.sv
// Package: register map, field positions and types of the status flag map
package psfm_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_TARGET_LIMIT = 6'h00;
  localparam logic [5:0] IDX_PRESS_LOW = 6'h01;
  localparam logic [5:0] IDX_PRESS_HIGH = 6'h02;
  localparam logic [5:0] IDX_RESID_LIMIT = 6'h03;
  localparam logic [5:0] IDX_VOLT_LOW = 6'h04;
  localparam logic [5:0] IDX_VOLT_HIGH = 6'h05;
  localparam logic [5:0] IDX_ENERGIZE_LIMIT = 6'h06;
  localparam logic [5:0] IDX_ENERGIZE_COUNT = 6'h07;
  localparam logic [5:0] IDX_SUMMARY = 6'h14;
  localparam logic [5:0] IDX_REG_DIAG = 6'h18;
  localparam logic [5:0] IDX_HUB_FAULT = 6'h1A;
  localparam logic [5:0] IDX_REG_QUALITY = 6'h1B;
  localparam logic [5:0] IDX_AUX_QUALITY = 6'h1C;

  // Reset values of the software limits
  localparam logic [15:0] RST_TARGET_LIMIT = 16'h03E8;
  localparam logic [15:0] RST_PRESS_LOW = 16'h0000;
  localparam logic [15:0] RST_PRESS_HIGH = 16'h03E8;
  localparam logic [15:0] RST_RESID_LIMIT = 16'h000A;
  localparam logic [15:0] RST_VOLT_LOW = 16'h00D8;
  localparam logic [15:0] RST_VOLT_HIGH = 16'h0108;
  localparam logic [31:0] RST_ENERGIZE_LIMIT = 32'hFFFFFFFF;

  // Settle band: pressure within one tenth of target
  localparam int SETTLE_DIVISOR = 10;

  // Energizing time unit, counted in milliseconds
  localparam int CLK_HZ = 125000000;
  localparam int ENERGIZE_UNIT_MS = 1;
  localparam int ENERGIZE_UNIT_CYCLES = CLK_HZ / 1000 * ENERGIZE_UNIT_MS;

  // Regulator diagnostic word bit positions
  localparam int DG_SETTLED = 0;
  localparam int DG_ENERGIZE = 3;
  localparam int DG_RESIDUAL = 4;
  localparam int DG_TARGET_OVER = 5;
  localparam int DG_LOW_RANGE = 6;
  localparam int DG_HIGH_RANGE = 7;
  localparam int DG_VOLT_LOW = 8;
  localparam int DG_VOLT_HIGH = 9;
  localparam int DG_ALARM = 10;
  localparam int DG_COMM_FAULT = 11;
  localparam int DG_VALVE_FAULT = 12;
  localparam int DG_SYS_FAULT = 13;
  localparam int DG_NVM_FAULT = 14;
  localparam int DG_ERROR = 15;

  // Hub fault byte bit positions
  localparam int HF_AUX_SHORT = 0;
  localparam int HF_LINK = 1;
  localparam int HF_VALVE_SHORT = 2;

  // Summary flag byte bit positions
  localparam int SF_FLOW_UNIT = 0;
  localparam int SF_FLOW_REF = 1;
  localparam int SF_FLOW_DIAG = 2;
  localparam int SF_TEMP_DIAG = 3;
  localparam int SF_PRESS_DIAG = 4;
  localparam int SF_FORCED = 5;
  localparam int SF_ERROR = 6;
  localparam int SF_SYS_ERROR = 7;

  // Number of ports that carry a quality byte
  localparam int NUM_PORTS = 2;

  // Per-port status, packed in quality-byte order (msb = bit 7)
  typedef struct packed {
    logic input_data_valid;
    logic event_pending;
    logic link_up;
    logic stored_params_valid;
    logic signal_line_short;
    logic supply_short;
    logic mapping_mismatch;
    logic device_identity_mismatch;
  } psfm_port_status_t;

  // Regulator measurements and fault reports
  typedef struct packed {
    logic [15:0] output_pressure;
    logic [15:0] target_pressure;
    logic [15:0] supply_voltage;
    logic valve_energized;
    logic comm_fault;
    logic valve_fault;
    logic system_fault;
    logic nvm_fault;
  } psfm_regulator_t;

  // Hub state and summary sources
  typedef struct packed {
    logic aux_supply_line_short;
    logic hub_link_up;
    logic valve_supply_short;
    logic flow_unit_cubic_feet;
    logic flow_ref_normal;
    logic flow_diag;
    logic temp_diag;
    logic forced_mode;
    logic system_error;
  } psfm_hub_t;
endpackage

// file: rtl/psfm_flag_map.sv
// Status flag map: derives process status bytes and serves them over Avalon-MM
`timescale 1ns/1ps
module psfm_flag_map #(
  parameter int ENERGIZE_UNIT_CYCLES = psfm_pkg::ENERGIZE_UNIT_CYCLES,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire psfm_pkg::psfm_regulator_t regulator_in,
  input wire psfm_pkg::psfm_hub_t hub_in,
  input wire psfm_pkg::psfm_port_status_t [psfm_pkg::NUM_PORTS-1:0] port_in
);

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Reset synchroniser; only the second stage feeds the design
  logic rst_meta_q; // First stage, read only by the second
  logic rst_sync_n_q; // Released reset used everywhere

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // Bus decode
  logic [5:0] word_idx; // Word index from the byte address
  logic addr_aligned; // Low two address bits are zero; upper bits are not checked
  logic bus_commit; // Access completes at this edge
  assign word_idx = avs_address[7:2];
  assign addr_aligned = (avs_address[1:0] == 2'h0);
  assign bus_commit = (avs_read || avs_write) && !avs_waitrequest;

  // Software limits
  logic [15:0] target_limit_q;
  logic [15:0] press_low_q;
  logic [15:0] press_high_q;
  logic [15:0] resid_limit_q;
  logic [15:0] volt_low_q;
  logic [15:0] volt_high_q;
  logic [31:0] energize_limit_q;

  // Limit registers take writes at the completing edge only
  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      target_limit_q <= psfm_pkg::RST_TARGET_LIMIT;
      press_low_q <= psfm_pkg::RST_PRESS_LOW;
      press_high_q <= psfm_pkg::RST_PRESS_HIGH;
      resid_limit_q <= psfm_pkg::RST_RESID_LIMIT;
      volt_low_q <= psfm_pkg::RST_VOLT_LOW;
      volt_high_q <= psfm_pkg::RST_VOLT_HIGH;
      energize_limit_q <= psfm_pkg::RST_ENERGIZE_LIMIT;
    end else if (bus_commit && avs_write && addr_aligned) begin
      case (word_idx)
        // Upper lanes of the merged word are dropped on purpose for 16-bit limits
        psfm_pkg::IDX_TARGET_LIMIT: begin
          target_limit_q <= 16'(be_merge({16'h0000, target_limit_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_PRESS_LOW: begin
          press_low_q <= 16'(be_merge({16'h0000, press_low_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_PRESS_HIGH: begin
          press_high_q <= 16'(be_merge({16'h0000, press_high_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_RESID_LIMIT: begin
          resid_limit_q <= 16'(be_merge({16'h0000, resid_limit_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_VOLT_LOW: begin
          volt_low_q <= 16'(be_merge({16'h0000, volt_low_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_VOLT_HIGH: begin
          volt_high_q <= 16'(be_merge({16'h0000, volt_high_q}, avs_writedata, avs_byteenable));
        end
        psfm_pkg::IDX_ENERGIZE_LIMIT: begin
          energize_limit_q <= be_merge(energize_limit_q, avs_writedata, avs_byteenable);
        end
        default: begin
          // Read-only or unmapped: write is dropped
        end
      endcase
    end
  end

  // Energizing time accumulator in whole time units
  logic [31:0] unit_cnt_q; // Cycles within the current unit
  logic [31:0] energize_ms_q; // Accumulated units, saturating

  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      unit_cnt_q <= 32'h00000000;
      energize_ms_q <= 32'h00000000;
    end else if (regulator_in.valve_energized) begin
      if (unit_cnt_q == 32'(ENERGIZE_UNIT_CYCLES - 1)) begin
        unit_cnt_q <= 32'h00000000;
        // Saturate so the notification never wraps back off
        if (energize_ms_q != 32'hFFFFFFFF) begin
          energize_ms_q <= energize_ms_q + 32'h00000001;
        end
      end else begin
        unit_cnt_q <= unit_cnt_q + 32'h00000001;
      end
    end
  end

  // Pressure comparisons
  logic [15:0] press_err; // Absolute pressure error
  logic [19:0] press_err_x; // Error scaled by the settle divisor
  logic settled;
  assign press_err = (regulator_in.output_pressure > regulator_in.target_pressure) ?
    (regulator_in.output_pressure - regulator_in.target_pressure) :
    (regulator_in.target_pressure - regulator_in.output_pressure);
  assign press_err_x = 20'(press_err) * 20'(psfm_pkg::SETTLE_DIVISOR);
  assign settled = (press_err_x <= {4'h0, regulator_in.target_pressure});

  // Residual pressure: sampled when the target falls to zero
  logic target_zero_q; // Target was zero last cycle
  logic residual_q; // Residual fault flag

  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      target_zero_q <= 1'b1;
      residual_q <= 1'b0;
    end else begin
      target_zero_q <= (regulator_in.target_pressure == 16'h0000);
      if (regulator_in.target_pressure != 16'h0000) begin
        // A new nonzero target clears the old fault
        residual_q <= 1'b0;
      end else if (!target_zero_q) begin
        residual_q <= (regulator_in.output_pressure > resid_limit_q);
      end
    end
  end

  // Regulator diagnostic word, refreshed every cycle
  logic [15:0] diag_q;
  logic [15:0] diag_d;

  always_comb begin
    diag_d = 16'h0000;
    diag_d[psfm_pkg::DG_SETTLED] = settled;
    diag_d[psfm_pkg::DG_ENERGIZE] = (energize_ms_q >= energize_limit_q);
    diag_d[psfm_pkg::DG_RESIDUAL] = residual_q;
    diag_d[psfm_pkg::DG_TARGET_OVER] = (regulator_in.target_pressure > target_limit_q);
    diag_d[psfm_pkg::DG_LOW_RANGE] = (regulator_in.output_pressure < press_low_q);
    diag_d[psfm_pkg::DG_HIGH_RANGE] = (regulator_in.output_pressure > press_high_q);
    diag_d[psfm_pkg::DG_VOLT_LOW] = (regulator_in.supply_voltage < volt_low_q);
    diag_d[psfm_pkg::DG_VOLT_HIGH] = (regulator_in.supply_voltage > volt_high_q);
    diag_d[psfm_pkg::DG_COMM_FAULT] = regulator_in.comm_fault;
    diag_d[psfm_pkg::DG_VALVE_FAULT] = regulator_in.valve_fault;
    diag_d[psfm_pkg::DG_SYS_FAULT] = regulator_in.system_fault;
    diag_d[psfm_pkg::DG_NVM_FAULT] = regulator_in.nvm_fault;
    // Summaries come from the same cycle's bits so they never lag them
    diag_d[psfm_pkg::DG_ALARM] = |diag_d[psfm_pkg::DG_VOLT_HIGH:psfm_pkg::DG_RESIDUAL];
    diag_d[psfm_pkg::DG_ERROR] = |diag_d[psfm_pkg::DG_NVM_FAULT:psfm_pkg::DG_COMM_FAULT];
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      diag_q <= 16'h0000;
    end else begin
      diag_q <= diag_d;
    end
  end

  // Hub fault and summary bytes
  logic [7:0] hub_q;
  logic [7:0] summary_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      hub_q <= 8'h00;
      summary_q <= 8'h00;
    end else begin
      hub_q <= 8'h00;
      hub_q[psfm_pkg::HF_AUX_SHORT] <= hub_in.aux_supply_line_short;
      hub_q[psfm_pkg::HF_LINK] <= hub_in.hub_link_up;
      hub_q[psfm_pkg::HF_VALVE_SHORT] <= hub_in.valve_supply_short;
      summary_q[psfm_pkg::SF_FLOW_UNIT] <= hub_in.flow_unit_cubic_feet;
      summary_q[psfm_pkg::SF_FLOW_REF] <= hub_in.flow_ref_normal;
      summary_q[psfm_pkg::SF_FLOW_DIAG] <= hub_in.flow_diag;
      summary_q[psfm_pkg::SF_TEMP_DIAG] <= hub_in.temp_diag;
      summary_q[psfm_pkg::SF_PRESS_DIAG] <= diag_d[psfm_pkg::DG_LOW_RANGE] | diag_d[psfm_pkg::DG_HIGH_RANGE];
      summary_q[psfm_pkg::SF_FORCED] <= hub_in.forced_mode;
      summary_q[psfm_pkg::SF_ERROR] <= diag_d[psfm_pkg::DG_ALARM] | diag_d[psfm_pkg::DG_ERROR];
      summary_q[psfm_pkg::SF_SYS_ERROR] <= hub_in.system_error;
    end
  end

  // Port quality bytes, one identical copy per port
  logic [7:0] quality_q [psfm_pkg::NUM_PORTS];

  for (genvar p = 0; p < psfm_pkg::NUM_PORTS; p++) begin : g_port
    // Field order of the struct already matches the byte layout
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
        quality_q[p] <= 8'h00;
      end else begin
        quality_q[p][0] <= port_in[p].device_identity_mismatch;
        quality_q[p][1] <= port_in[p].mapping_mismatch;
        quality_q[p][2] <= port_in[p].supply_short;
        quality_q[p][3] <= port_in[p].signal_line_short;
        quality_q[p][4] <= port_in[p].stored_params_valid;
        quality_q[p][5] <= port_in[p].link_up;
        quality_q[p][6] <= port_in[p].event_pending;
        quality_q[p][7] <= port_in[p].input_data_valid;
      end
    end
  end

  // Read mux; unmapped or misaligned reads return zero
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (addr_aligned) begin
      case (word_idx)
        psfm_pkg::IDX_TARGET_LIMIT: rdata_d = {16'h0000, target_limit_q};
        psfm_pkg::IDX_PRESS_LOW: rdata_d = {16'h0000, press_low_q};
        psfm_pkg::IDX_PRESS_HIGH: rdata_d = {16'h0000, press_high_q};
        psfm_pkg::IDX_RESID_LIMIT: rdata_d = {16'h0000, resid_limit_q};
        psfm_pkg::IDX_VOLT_LOW: rdata_d = {16'h0000, volt_low_q};
        psfm_pkg::IDX_VOLT_HIGH: rdata_d = {16'h0000, volt_high_q};
        psfm_pkg::IDX_ENERGIZE_LIMIT: rdata_d = energize_limit_q;
        psfm_pkg::IDX_ENERGIZE_COUNT: rdata_d = energize_ms_q;
        psfm_pkg::IDX_SUMMARY: rdata_d = {24'h000000, summary_q};
        psfm_pkg::IDX_REG_DIAG: rdata_d = {16'h0000, diag_q};
        psfm_pkg::IDX_HUB_FAULT: rdata_d = {24'h000000, hub_q};
        psfm_pkg::IDX_REG_QUALITY: rdata_d = {24'h000000, quality_q[0]};
        psfm_pkg::IDX_AUX_QUALITY: rdata_d = {24'h000000, quality_q[1]};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Wait-state engine: one wait cycle, then a one-cycle completion.
  // Waitrequest idles high so it can come from a flop without a
  // combinational path from the request.
  always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      // Data latched one cycle early and held through completion
      avs_readdata <= avs_read ? rdata_d : 32'h00000000;
    end
  end

endmodule

// file: test/psfm_flag_map_checker.sv
// Checker: concurrent properties on the status flag map ports
`timescale 1ns/1ps
module psfm_flag_map_checker #(
  parameter int ENERGIZE_UNIT_CYCLES = 4,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire psfm_pkg::psfm_regulator_t regulator_in,
  input wire psfm_pkg::psfm_hub_t hub_in,
  input wire psfm_pkg::psfm_port_status_t [psfm_pkg::NUM_PORTS-1:0] port_in
);
  // All status inputs side by side
  logic [77:0] now_w;
  logic [77:0] prev_q;
  // Edges since the inputs last moved; flop and read pipeline lag means only quiet reads are comparable
  logic [2:0] quiet_q;
  logic done_rd;
  assign now_w = {regulator_in, hub_in, port_in};
  assign done_rd = avs_read && !avs_waitrequest;

  // Quiet counter, saturating at seven
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= '0;
      quiet_q <= 3'h0;
    end else begin
      prev_q <= now_w;
      quiet_q <= (now_w != prev_q) ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_alarm_or;
    done_rd && avs_address == 8'h60 |-> avs_readdata[10] == (|avs_readdata[9:4]);
  endproperty
  a_alarm_or: assert property (p_alarm_or) else $error("alarm summary bit wrong");
  property p_error_or;
    done_rd && avs_address == 8'h60 |-> avs_readdata[15] == (|avs_readdata[14:11]);
  endproperty
  a_error_or: assert property (p_error_or) else $error("error summary bit wrong");
  property p_diag_zero;
    done_rd && avs_address == 8'h60 |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[2:1] == 2'h0;
  endproperty
  a_diag_zero: assert property (p_diag_zero) else $error("diag reserved bits set");
  property p_hub_map;
    done_rd && avs_address == 8'h68 && quiet_q >= 3'h4
      |-> avs_readdata == {29'h0, hub_in.valve_supply_short, hub_in.hub_link_up, hub_in.aux_supply_line_short};
  endproperty
  a_hub_map: assert property (p_hub_map) else $error("hub fault byte wrong");
  property p_reg_quality;
    done_rd && avs_address == 8'h6C && quiet_q >= 3'h4 |-> avs_readdata == {24'h0, port_in[0]};
  endproperty
  a_reg_quality: assert property (p_reg_quality) else $error("regulator quality byte wrong");
  property p_aux_quality;
    done_rd && avs_address == 8'h70 && quiet_q >= 3'h4 |-> avs_readdata == {24'h0, port_in[1]};
  endproperty
  a_aux_quality: assert property (p_aux_quality) else $error("aux quality byte wrong");
  property p_faults;
    done_rd && avs_address == 8'h60 && quiet_q >= 3'h4 |-> avs_readdata[14:11] ==
      {regulator_in.nvm_fault, regulator_in.system_fault, regulator_in.valve_fault, regulator_in.comm_fault};
  endproperty
  a_faults: assert property (p_faults) else $error("internal fault bits wrong");
  // Upper limits are left at reset here, so the reset figures decide
  property p_ranges;
    done_rd && avs_address == 8'h60 && quiet_q >= 3'h4
      |-> avs_readdata[9] == (regulator_in.supply_voltage > psfm_pkg::RST_VOLT_HIGH)
      && avs_readdata[7] == (regulator_in.output_pressure > psfm_pkg::RST_PRESS_HIGH);
  endproperty
  a_ranges: assert property (p_ranges) else $error("upper range bits wrong");
  // Completion lasts one cycle, so a held request cannot complete on two consecutive edges
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle"); // Bus timing
  // A fresh request is answered after exactly one wait state
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered after one wait"); // Bus timing
endmodule
bind psfm_flag_map psfm_flag_map_checker #(.ENERGIZE_UNIT_CYCLES(ENERGIZE_UNIT_CYCLES), .ADDR_W(ADDR_W))
  u_psfm_flag_map_checker (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .regulator_in(regulator_in),
  .hub_in(hub_in), .port_in(port_in));

// file: test/psfm_ctrl_model.sv
// Fieldbus controller model: Avalon-MM master that polls the status bytes
`timescale 1ns/1ps
module psfm_ctrl_model (
  input wire logic sys_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus; full lanes always, the block has no narrower need
  initial begin
    avs_address = 8'hFF;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // One access, held until waitrequest is sampled low; only the watchdog ends a stuck wait
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    avs_address <= ~a;
    avs_writedata <= ~wd;
  endtask
endmodule

// file: test/tb_psfm_flag_map.sv
// Testbench: status flag map driven through the controller model
`timescale 1ns/1ps
module tb_psfm_flag_map;
  logic sys_clk;
  logic reset_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  psfm_pkg::psfm_regulator_t regulator_in;
  psfm_pkg::psfm_hub_t hub_in;
  psfm_pkg::psfm_port_status_t [1:0] port_in;
  logic [31:0] rdata;
  logic [15:0] press_low = 16'h0064; // Low limit the bench programs
  int num_errors = 0;
  int cmp_count = 0;
  // Regulator vectors: pressure, target, voltage, faults {comm, valve, system, nvm}
  logic [15:0] vp [6] = '{16'h01F4, 16'h0227, 16'h0226, 16'h03E9, 16'h0032, 16'h0064};
  logic [15:0] vt [6] = '{16'h01F4, 16'h01F4, 16'h01F4, 16'h03E9, 16'h03E8, 16'h03E8};
  logic [15:0] vv [6] = '{16'h00F0, 16'h00F0, 16'h00D7, 16'h0109, 16'h00D8, 16'h0108};
  logic [3:0] vf [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h0};

  psfm_flag_map #(.ENERGIZE_UNIT_CYCLES(4), .ADDR_W(8)) u_psfm_flag_map (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .regulator_in(regulator_in), .hub_in(hub_in), .port_in(port_in));
  psfm_ctrl_model u_psfm_ctrl_model (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    u_psfm_ctrl_model.access(1'b0, a, 32'h0, rdata);
    chk(what, exp, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_psfm_ctrl_model.access(1'b1, a, d, rdata);
  endtask
  // Inputs need an edge into the flops plus margin before reads compare
  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic set_vec(input int i);
    regulator_in <= {vp[i], vt[i], vv[i], 1'b0, vf[i]};
  endtask

  // Expected diagnostic word from the regulator inputs and current limits
  function automatic logic [15:0] exp_diag(input psfm_pkg::psfm_regulator_t r, input logic res, input logic en);
    logic [15:0] e;
    int d;
    d = (r.output_pressure > r.target_pressure) ? r.output_pressure - r.target_pressure
                                                : r.target_pressure - r.output_pressure;
    e = 16'h0000;
    e[0] = (10 * d <= int'(r.target_pressure));
    e[3] = en;
    e[4] = res;
    e[5] = r.target_pressure > psfm_pkg::RST_TARGET_LIMIT;
    e[6] = r.output_pressure < press_low;
    e[7] = r.output_pressure > psfm_pkg::RST_PRESS_HIGH;
    e[8] = r.supply_voltage < psfm_pkg::RST_VOLT_LOW;
    e[9] = r.supply_voltage > psfm_pkg::RST_VOLT_HIGH;
    e[10] = |e[9:4];
    e[14:11] = {r.nvm_fault, r.system_fault, r.valve_fault, r.comm_fault};
    e[15] = |e[14:11];
    return e;
  endfunction

  // Limit reset values, limit write, unmapped and misaligned reads
  task automatic t_regs();
    rd_chk("target_limit", 8'h00, {16'h0, psfm_pkg::RST_TARGET_LIMIT});
    rd_chk("volt_high", 8'h14, {16'h0, psfm_pkg::RST_VOLT_HIGH});
    wr(8'h04, {16'h0, press_low});
    rd_chk("press_low", 8'h04, {16'h0, press_low});
    rd_chk("unmapped", 8'h74, 32'h0);
    rd_chk("misaligned", 8'h6D, 32'h0);
    $display("test regs done");
  endtask
  // Every regulator vector through the diagnostic word
  task automatic t_diag();
    for (int i = 0; i < 6; i++) begin
      set_vec(i);
      settle();
      rd_chk("diag", 8'h60, {16'h0, exp_diag({vp[i], vt[i], vv[i], 1'b0, vf[i]}, 1'b0, 1'b0)});
    end
    $display("test diag done");
  endtask
  // Walking ones over hub, port 0 and summary sources; walking zeros over port 1
  task automatic t_status();
    logic [15:0] d;
    for (int i = 0; i < 9; i++) begin
      set_vec(i % 6);
      hub_in <= 9'h001 << i;
      port_in[0] <= 8'h01 << (i % 8);
      port_in[1] <= ~(8'h01 << (i % 8));
      settle();
      d = exp_diag(regulator_in, 1'b0, 1'b0);
      rd_chk("hub", 8'h68, {29'h0, hub_in.valve_supply_short, hub_in.hub_link_up, hub_in.aux_supply_line_short});
      rd_chk("reg_quality", 8'h6C, {24'h0, port_in[0]});
      rd_chk("aux_quality", 8'h70, {24'h0, port_in[1]});
      rd_chk("summary", 8'h50, {24'h0, hub_in.system_error, d[10] | d[15], hub_in.forced_mode, d[6] | d[7],
        hub_in.temp_diag, hub_in.flow_diag, hub_in.flow_ref_normal, hub_in.flow_unit_cubic_feet});
    end
    // Writes to a read-only byte are dropped
    wr(8'h6C, 32'hFFFFFFFF);
    rd_chk("quality_ro", 8'h6C, {24'h0, port_in[0]});
    $display("test status done");
  endtask
  // Target cleared with pressure just above and at the residual limit
  task automatic t_residual();
    logic [15:0] p;
    for (int i = 0; i < 2; i++) begin
      p = psfm_pkg::RST_RESID_LIMIT + 16'(1 - i);
      regulator_in <= {16'h0064, 16'h0064, 16'h00F0, 5'h00};
      settle();
      regulator_in <= {p, 16'h0000, 16'h00F0, 5'h00};
      settle();
      rd_chk("residual", 8'h60, {16'h0, exp_diag({p, 16'h0000, 16'h00F0, 5'h00}, i == 0, 1'b0)});
    end
    $display("test residual done");
  endtask
  // Energizing time of one unit, then five, against a limit of three
  task automatic t_energize();
    wr(8'h18, 32'h00000003);
    regulator_in <= {16'h0064, 16'h0064, 16'h00F0, 5'h10};
    settle();
    rd_chk("energize_early", 8'h60, {16'h0, exp_diag(regulator_in, 1'b0, 1'b0)});
    repeat (16) @(posedge sys_clk);
    rd_chk("energize_late", 8'h60, {16'h0, exp_diag(regulator_in, 1'b0, 1'b1)});
    $display("test energize done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    regulator_in = '0;
    hub_in = '0;
    port_in = '0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_diag();
    t_status();
    t_residual();
    t_energize();
    end_sim();
  end
endmodule
